// ===== common/tws_pkg.sv
// Shared constants and carrier types of the three-wire serial port.
// Assumes a 32-bit classic Wishbone master with 16-bit byte addresses.
package tws_pkg;

  // ************************************************************
  // register map (byte addresses, one aligned word each)
  // ************************************************************
  localparam logic [15:0] MODE_ADDR = 16'hff80;
  localparam logic [15:0] MODE_B_ADDR = 16'hff88;
  localparam logic [15:0] CLKSEL_ADDR = 16'hff84;
  localparam logic [15:0] TXBUF_ADDR = 16'hff90;
  localparam logic [15:0] SHIFT_ADDR = 16'hff94;
  localparam logic [15:0] MODE_SET_ADDR = 16'hff98;
  localparam logic [15:0] MODE_CLR_ADDR = 16'hff9c;
  localparam logic [15:0] STATUS_ADDR = 16'hffa0;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int ENABLE_BIT = 7;
  localparam int TRMD_BIT = 6;
  localparam int SSE_BIT = 5;
  localparam int DIR_BIT = 4;
  localparam int CIP_BIT = 0;
  localparam logic [7:0] MODE_WR_MASK = 8'hf0;
  localparam logic [7:0] MODE_RST = 8'h00;

  localparam int CKP_BIT = 4;
  localparam int DAP_BIT = 3;
  localparam int CKS_LSB = 0;
  localparam int CKS_W = 3;
  localparam logic [CKS_W-1:0] CKS_EXT = 3'h7;
  localparam logic [7:0] CLKSEL_WR_MASK = 8'h1f;
  localparam logic [7:0] CLKSEL_RST = 8'h00;

  localparam logic [7:0] TXBUF_RST = 8'h00;
  localparam logic [7:0] SHIFT_RST = 8'h00;

  localparam int STAT_CNT_LSB = 0;
  localparam int STAT_SCK_BIT = 4;
  localparam int STAT_SI_BIT = 5;
  localparam int STAT_SS_BIT = 6;

  // ************************************************************
  // timing
  // ************************************************************
  localparam logic [3:0] BITS_PER_FRAME = 4'h8;
  localparam int HALF_W = 6;
  localparam int SYNC_STAGES = 2;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic {TWS_IDLE, TWS_RUN} tws_phase_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [15:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } tws_wb_req_t;

  typedef struct packed {
    tws_phase_t phase;
    logic [7:0] mode;
    logic [7:0] clksel;
    logic [7:0] txbuf;
    logic [7:0] sr;
    logic [3:0] cnt;
    logic [HALF_W-1:0] half;
    logic sck_lvl;
    logic sck_oe;
    logic sck_prev;
    logic so;
    logic so_oe;
    logic si_lat;
    logic ack;
    logic [31:0] dat;
  } tws_state_t;

endpackage

// ===== rtl/tws_sync.sv
// Two-stage synchroniser for a group of asynchronous levels.
// Assumes the inputs come from pins outside the sys_clk_i domain.
`timescale 1ns/10ps
`default_nettype none
module tws_sync #(
  parameter int WIDTH = 3
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  // ************************************************************
  // stages
  // ************************************************************
  // the first stage feeds the second and nothing else
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule
`default_nettype wire

// ===== rtl/tws_port.sv
// Three-wire clocked serial port with its mode, clock and data registers.
// Assumes a classic Wishbone master on sys_clk_i and a tristate pad
// outside that resolves each pin from its output enable.
//
// Behaviour
// - buffer write with enable and txrx mode starts
// - written byte loads shifter, goes out serially
// - slave select gates transmit start, low only
// - 8-bit shifter, read by software as byte
// - receive mode: shifter read starts a reception
// - reception shifts sampled data-in bits in
// - slave select gates receive start, low only
// - enable cleared resets busy flag and shifter
// - mode bit 7 enables or stops the port
// - receive mode holds data-out constantly low
// - mode bit 0 reads busy, read only
// - mode bit 5 selects slave select use, external clock only
// - reset clears buffer, shifter and mode to zero
// - default mode releases clock and data pins
// - mode register takes bit and byte writes
// - clock select: divide 2 to 128 or external
`timescale 1ns/10ps
`default_nettype none
module tws_port (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire tws_pkg::tws_wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_o,
  input wire logic serial_data_in_i,
  output logic serial_data_out_o,
  output logic serial_data_out_oe_o,
  input wire logic slave_select_input_n_i
);
  import tws_pkg::*;

  // ************************************************************
  // pin synchronisation
  // ************************************************************
  logic [2:0] pins_s;
  logic sck_s;
  logic si_s;
  logic ss_n_s;

  // the pins cross into sys_clk_i here; nothing below reads them raw
  tws_sync #(
    .WIDTH(3)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .async_i({slave_select_input_n_i, serial_data_in_i, serial_clock_pin_i}),
    .sync_o(pins_s)
  );

  assign sck_s = pins_s[0];
  assign si_s = pins_s[1];
  assign ss_n_s = pins_s[2];

  // ************************************************************
  // helpers
  // ************************************************************
  // one bit order serves both directions, so one pair of helpers does
  function automatic logic out_bit(input logic [7:0] sr, input logic lsb_first);
    out_bit = lsb_first ? sr[0] : sr[7];
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] sr, input logic lsb_first,
                                          input logic din);
    shift_in = lsb_first ? {din, sr[7:1]} : {sr[6:0], din};
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  // all state sits in one struct; d is its next value
  tws_state_t q;
  tws_state_t d;

  logic req;
  logic acc;
  logic [13:0] word;
  logic en;
  logic trmd;
  logic sse;
  logic lsb_first;
  logic clock_polarity_select;
  logic data_phase_select;
  logic [CKS_W-1:0] clock_divider_select;
  logic ext_clk;
  logic idle_lvl;
  logic ss_ok;
  logic start_tx;
  logic start_rx;
  logic lead;
  logic trail;
  logic din;
  logic [HALF_W-1:0] half_max;
  logic [7:0] mode_rd;
  logic [7:0] wr_byte;

  assign en = q.mode[ENABLE_BIT];
  assign trmd = q.mode[TRMD_BIT];
  assign sse = q.mode[SSE_BIT];
  assign lsb_first = q.mode[DIR_BIT];
  assign clock_polarity_select = q.clksel[CKP_BIT];
  assign data_phase_select = q.clksel[DAP_BIT];
  assign clock_divider_select = q.clksel[CKS_LSB +: CKS_W];
  assign ext_clk = (clock_divider_select == CKS_EXT);
  // type 1 (clksel all zero) idles the clock high
  assign idle_lvl = ~clock_polarity_select;
  // slave select only matters for an externally clocked slave
  assign ss_ok = ~(sse & ext_clk) | ~ss_n_s;
  assign half_max = HALF_W'((7'h01 << clock_divider_select) - 7'h01);
  assign mode_rd = {q.mode[7:1], (q.phase == TWS_RUN)};

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    d = q;
    req = wb_req_i.cyc & wb_req_i.stb;
    acc = req & ~q.ack;
    word = wb_req_i.adr[15:2];
    wr_byte = wb_req_i.dat[7:0];
    start_tx = 1'b0;
    start_rx = 1'b0;
    lead = 1'b0;
    trail = 1'b0;
    din = 1'b0;

    // ************************************************************
    // bus slave: answers one edge after the request
    // ************************************************************
    // a request is taken only while no ack stands, so a held stb
    // earns a fresh answer on every second edge
    d.ack = acc;
    d.dat = 32'h0000_0000;
    if (acc) begin
      unique case (word)
        MODE_ADDR[15:2]: begin
          d.dat = {24'h00_0000, mode_rd};
          if (wb_req_i.we && wb_req_i.sel[0]) begin
            // fields other than enable are frozen mid-frame
            if (q.phase == TWS_RUN) begin
              d.mode[ENABLE_BIT] = wr_byte[ENABLE_BIT];
            end else begin
              d.mode = wr_byte & MODE_WR_MASK;
            end
          end
        end
        MODE_SET_ADDR[15:2]: begin
          d.dat = {24'h00_0000, mode_rd};
          if (wb_req_i.we && wb_req_i.sel[0]) begin
            if (q.phase == TWS_RUN) begin
              d.mode[ENABLE_BIT] = q.mode[ENABLE_BIT] | wr_byte[ENABLE_BIT];
            end else begin
              d.mode = q.mode | (wr_byte & MODE_WR_MASK);
            end
          end
        end
        MODE_CLR_ADDR[15:2]: begin
          d.dat = {24'h00_0000, mode_rd};
          if (wb_req_i.we && wb_req_i.sel[0]) begin
            if (q.phase == TWS_RUN) begin
              d.mode[ENABLE_BIT] = q.mode[ENABLE_BIT] & ~wr_byte[ENABLE_BIT];
            end else begin
              d.mode = q.mode & ~(wr_byte & MODE_WR_MASK);
            end
          end
        end
        CLKSEL_ADDR[15:2]: begin
          d.dat = {24'h00_0000, q.clksel};
          // a clock change under an enabled port is dropped
          if (wb_req_i.we && wb_req_i.sel[0] && !en) begin
            d.clksel = wr_byte & CLKSEL_WR_MASK;
          end
        end
        TXBUF_ADDR[15:2]: begin
          d.dat = {24'h00_0000, q.txbuf};
          if (wb_req_i.we && wb_req_i.sel[0]) begin
            d.txbuf = wr_byte;
            start_tx = en & trmd & ss_ok & (q.phase == TWS_IDLE);
          end
        end
        SHIFT_ADDR[15:2]: begin
          d.dat = {24'h00_0000, q.sr};
          if (!wb_req_i.we) begin
            start_rx = en & ~trmd & ss_ok & (q.phase == TWS_IDLE);
          end
        end
        STATUS_ADDR[15:2]: begin
          d.dat = '0;
          d.dat[STAT_CNT_LSB +: 4] = q.cnt;
          d.dat[STAT_SCK_BIT] = sck_s;
          d.dat[STAT_SI_BIT] = si_s;
          d.dat[STAT_SS_BIT] = ss_n_s;
        end
        default: begin
          d.dat = 32'h0000_0000;
        end
      endcase
    end

    // ************************************************************
    // serial clock edges
    // ************************************************************
    // an external clock is seen through the synchroniser, a few cycles
    // late; it must stay well below a sixth of the system clock
    d.sck_prev = sck_s;
    if (q.phase == TWS_RUN) begin
      if (ext_clk) begin
        lead = (q.sck_prev == idle_lvl) && (sck_s != idle_lvl);
        trail = (q.sck_prev != idle_lvl) && (sck_s == idle_lvl);
      end else if (q.half == half_max) begin
        d.half = '0;
        lead = (q.sck_lvl == idle_lvl);
        trail = ~lead;
        d.sck_lvl = ~q.sck_lvl;
      end else begin
        d.half = q.half + 1'b1;
      end
    end else begin
      d.half = '0;
      d.sck_lvl = idle_lvl;
    end

    // ************************************************************
    // shifting
    // ************************************************************
    // phase 1 latches data-in on the leading edge, so the trailing
    // edge shift uses a value that stood for a whole half period
    if (q.phase == TWS_RUN) begin
      if (lead) begin
        if (data_phase_select) begin
          d.si_lat = si_s;
        end else begin
          d.so = out_bit(q.sr, lsb_first);
        end
      end
      if (trail) begin
        din = data_phase_select ? q.si_lat : si_s;
        d.sr = shift_in(q.sr, lsb_first, din);
        d.cnt = q.cnt + 1'b1;
        if (q.cnt == BITS_PER_FRAME - 4'h1) begin
          d.phase = TWS_IDLE;
          d.cnt = '0;
        end
      end
      if (data_phase_select) begin
        d.so = out_bit(d.sr, lsb_first);
      end
    end

    // ************************************************************
    // frame start
    // ************************************************************
    // a start that meets a disable in the same cycle loses below
    if (start_tx || start_rx) begin
      d.phase = TWS_RUN;
      d.cnt = '0;
      d.half = '0;
      d.sck_lvl = idle_lvl;
      if (start_tx) begin
        d.sr = wr_byte;
      end
      if (data_phase_select) begin
        d.so = out_bit(d.sr, lsb_first);
      end
    end

    // ************************************************************
    // disable wins over everything in flight
    // ************************************************************
    // synchronous here: the clear lands on the edge that takes the write
    if (!d.mode[ENABLE_BIT]) begin
      d.phase = TWS_IDLE;
      d.sr = SHIFT_RST;
      d.cnt = '0;
      d.half = '0;
      d.sck_lvl = idle_lvl;
    end

    // ************************************************************
    // pin drive
    // ************************************************************
    // data-out is forced low after all shifting logic, so no path can
    // leak a bit in receive-only mode
    d.sck_oe = d.mode[ENABLE_BIT] & ~(d.clksel[CKS_LSB +: CKS_W] == CKS_EXT);
    d.so_oe = d.mode[ENABLE_BIT];
    if (!d.mode[ENABLE_BIT] || !d.mode[TRMD_BIT]) begin
      d.so = 1'b0;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  // reset loads constants only; the pins come up released
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q.phase <= TWS_IDLE;
      q.mode <= MODE_RST;
      q.clksel <= CLKSEL_RST;
      q.txbuf <= TXBUF_RST;
      q.sr <= SHIFT_RST;
      q.cnt <= '0;
      q.half <= '0;
      q.sck_lvl <= 1'b1;
      q.sck_oe <= 1'b0;
      q.sck_prev <= 1'b0;
      q.so <= 1'b0;
      q.so_oe <= 1'b0;
      q.si_lat <= 1'b0;
      q.ack <= 1'b0;
      q.dat <= 32'h0000_0000;
    end else begin
      q <= d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // every output is a plain flop of q
  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;
  assign serial_clock_pin_o = q.sck_lvl;
  assign serial_clock_pin_oe_o = q.sck_oe;
  assign serial_data_out_o = q.so;
  assign serial_data_out_oe_o = q.so_oe;

endmodule
`default_nettype wire

// ===== sim/tws_port_props.sv
// Concurrent checks on the register bus and pins of the serial port.
// Assumes tws_pkg is compiled first; bound onto every tws_port.
`timescale 1ns/10ps
`default_nettype none
module tws_port_props
  import tws_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire tws_pkg::tws_wb_req_t wb_req_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic serial_clock_pin_o,
  input wire logic serial_clock_pin_oe_o,
  input wire logic serial_data_out_o,
  input wire logic serial_data_out_oe_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic wr_mode;
  // a mode write counts only at the edge that takes it
  assign wr_mode = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && !wb_ack_o
    && wb_req_i.sel[0] && wb_req_i.adr[15:2] == MODE_ADDR[15:2];
  logic ckp_q;
  // the clock idles at the inverse of the polarity last accepted; a
  // clock write counts only while the port is disabled
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ckp_q <= 1'b0;
    end else if (wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && !wb_ack_o
        && wb_req_i.sel[0] && wb_req_i.adr[15:2] == CLKSEL_ADDR[15:2]
        && !serial_data_out_oe_o) begin
      ckp_q <= wb_req_i.dat[CKP_BIT];
    end
  end
  // ************
  // properties
  // ************
  property p_ack_one;
    wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack missing");
  property p_ack_drop;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack too long");
  property p_dat_zero;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_dat_zero: assert property (p_dat_zero) else $error("data outside ack");
  property p_upper_zero;
    wb_ack_o |-> wb_dat_o[31:8] == 24'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
  property p_reset_out;
    $fell(rst_i) |-> !wb_ack_o && !serial_clock_pin_oe_o && !serial_data_out_oe_o;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("pins after reset");
  property p_en_on;
    wr_mode && wb_req_i.dat[7] |-> ##[1:3] serial_data_out_oe_o;
  endproperty
  a_en_on: assert property (p_en_on) else $error("enable ignored");
  property p_en_off;
    wr_mode && !wb_req_i.dat[7] |-> ##[1:3] !serial_data_out_oe_o && !serial_data_out_o;
  endproperty
  a_en_off: assert property (p_en_off) else $error("disable ignored");
  property p_so_free;
    !serial_data_out_oe_o |-> !serial_data_out_o && !serial_clock_pin_oe_o;
  endproperty
  a_so_free: assert property (p_so_free) else $error("pins not released");
  property p_half;
    $changed(serial_clock_pin_o) && serial_clock_pin_oe_o && serial_clock_pin_o == ckp_q
      |-> ##[1:128] serial_clock_pin_o != ckp_q;
  endproperty
  a_half: assert property (p_half) else $error("clock stuck off idle");
endmodule
bind tws_port tws_port_props u_props (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .wb_req_i(wb_req_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .serial_clock_pin_o(serial_clock_pin_o),
  .serial_clock_pin_oe_o(serial_clock_pin_oe_o),
  .serial_data_out_o(serial_data_out_o),
  .serial_data_out_oe_o(serial_data_out_oe_o)
);
`default_nettype wire

// ===== sim/tws_peer.sv
// Peripheral on the far side of the link: sends a byte msb first,
// records what it receives. Assumes polarity 0; data taken on the
// rise, or on the fall when phase_i is high.
`timescale 1ns/10ps
`default_nettype none
module tws_peer (
  input wire logic sys_clk_i,
  input wire logic sck_i,
  input wire logic sel_i,
  input wire logic so_i,
  input wire logic phase_i,
  input wire logic [7:0] tx_byte_i,
  output logic si_o = 1'b0,
  output logic [7:0] rx_byte_o = 8'h00
);
  logic sck_q = 1'b1;
  int n = 0;
  always @(posedge sys_clk_i) begin
    sck_q <= sck_i;
    if (!sel_i) begin
      n <= 0;
    end else begin
      if (sck_i && !sck_q) begin
        n <= (n + 1) % 8;
      end
      // phase 1 moves data-out on the trailing rise, so take it on the fall
      if (phase_i ? (!sck_i && sck_q) : (sck_i && !sck_q)) begin
        rx_byte_o <= {rx_byte_o[6:0], so_i};
      end
    end
    // unselected line wanders so a stale bit never looks valid
    si_o <= sel_i ? tx_byte_i[7 - n] : ~si_o;
  end
endmodule
`default_nettype wire

// ===== sim/tws_port_tb.sv
// Self-checking bench for tws_port: bus tasks, a peer and expectations.
// Assumes tws_pkg, the design, the checker and tws_peer are compiled.
`timescale 1ns/10ps
`default_nettype none
module tws_port_tb;
  import tws_pkg::*;
  logic clk = 0, rst = 1, ext_sck = 1, ss_n = 1, ph = 0;
  logic ack, sck, sck_oe, so, so_oe, si;
  logic [31:0] dat;
  logic [7:0] peer_tx = 8'h00, peer_rx, r, tx;
  tws_wb_req_t req = '0;
  int n_errors = 0, check_count = 0, seed = 62949, d;
  logic [15:0] regs [5] = '{MODE_ADDR, CLKSEL_ADDR, TXBUF_ADDR, SHIFT_ADDR, MODE_B_ADDR};
  wire logic sck_w = sck_oe ? sck : ext_sck;
  always #5 clk = ~clk;
  tws_port dut (.sys_clk_i(clk), .rst_i(rst), .wb_req_i(req), .wb_dat_o(dat),
    .wb_ack_o(ack), .serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck),
    .serial_clock_pin_oe_o(sck_oe), .serial_data_in_i(si), .serial_data_out_o(so),
    .serial_data_out_oe_o(so_oe), .slave_select_input_n_i(ss_n));
  tws_peer peer (.sys_clk_i(clk), .sck_i(sck_w), .sel_i(so_oe), .so_i(so),
    .phase_i(ph), .tx_byte_i(peer_tx), .si_o(si), .rx_byte_o(peer_rx));
  // ************
  // tasks
  // ************
  function automatic logic [7:0] rev(input logic [7:0] x);
    return {<<{x}};
  endfunction
  task results;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bytes seen by the peer on the link
  task chk_link(input string nm, input logic [7:0] e, input logic [7:0] g);
    chk({"link ", nm}, e, g);
  endtask
  task wb(input logic w, input logic [15:0] a, input logic [7:0] v, output logic [7:0] q);
    int i;
    i = 0;
    req <= '{1'b1, 1'b1, w, a, 4'h1, {24'h0, v}};
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    if (i >= 20) begin
      n_errors++;
      results;
    end
    q = dat[7:0];
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
    @(posedge clk);
  endtask
  // starts a frame and watches busy across its 128-cycle length at divide 16
  task frame(input logic w, input logic [15:0] a, input logic [7:0] m);
    wb(w, a, tx, r);
    repeat (118) @(posedge clk);
    wb(0, MODE_ADDR, 0, r);
    chk("busy", m | 8'h01, r);
    repeat (8) @(posedge clk);
    wb(0, MODE_ADDR, 0, r);
    chk("done", m, r);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (d = 0; d < 5; d++) begin
      wb(0, regs[d], 0, r);
      chk("reset", 8'h00, r);
    end
    wb(1, CLKSEL_ADDR, 8'h03, r);
    for (d = 0; d < 2; d++) begin
      wb(1, MODE_ADDR, d ? 8'hd0 : 8'hc0, r);
      tx = $random(seed);
      peer_tx <= $random(seed);
      frame(1, TXBUF_ADDR, d ? 8'hd0 : 8'hc0);
      wb(0, SHIFT_ADDR, 0, r);
      chk("rx", d ? rev(peer_tx) : peer_tx, r);
      chk_link("tx", d ? rev(tx) : tx, peer_rx);
    end
    wb(1, MODE_ADDR, 8'h80, r);
    peer_tx <= $random(seed);
    frame(0, SHIFT_ADDR, 8'h80);
    wb(0, SHIFT_ADDR, 0, r);
    chk("rx_only", peer_tx, r);
    chk_link("so_low", 8'h00, peer_rx);
    wb(1, MODE_ADDR, 8'h00, r);
    chk("released", 8'h00, {6'h00, sck_oe, so_oe});
    wb(1, CLKSEL_ADDR, 8'h0b, r);
    ph <= 1'b1;
    wb(1, MODE_ADDR, 8'hc0, r);
    tx = 8'($random(seed));
    peer_tx <= 8'($random(seed));
    frame(1, TXBUF_ADDR, 8'hc0);
    wb(0, SHIFT_ADDR, 0, r);
    chk("rx_phase1", peer_tx, r);
    chk_link("tx_phase1", tx, peer_rx);
    ph <= 1'b0;
    wb(1, TXBUF_ADDR, 8'h5a, r);
    repeat (40) @(posedge clk);
    wb(1, MODE_ADDR, 8'h40, r);
    wb(0, MODE_ADDR, 0, r);
    chk("off", 8'h40, r);
    wb(0, SHIFT_ADDR, 0, r);
    chk("cleared", 8'h00, r);
    wb(0, TXBUF_ADDR, 0, r);
    chk("txbuf", 8'h5a, r);
    wb(1, CLKSEL_ADDR, 8'h07, r);
    wb(1, MODE_SET_ADDR, 8'ha0, r);
    wb(1, TXBUF_ADDR, 8'h33, r);
    wb(0, MODE_ADDR, 0, r);
    chk("ss_high", 8'he0, r);
    ss_n <= 1'b0;
    peer_tx <= 8'($random(seed));
    repeat (4) @(posedge clk);
    wb(1, TXBUF_ADDR, 8'h33, r);
    wb(0, MODE_ADDR, 0, r);
    chk("ss_low", 8'he1, r);
    // external clock of 160 ns, moved only on system clock edges
    repeat (8) begin
      ext_sck <= 1'b0;
      repeat (8) @(posedge clk);
      ext_sck <= 1'b1;
      repeat (8) @(posedge clk);
    end
    repeat (6) @(posedge clk);
    wb(0, MODE_ADDR, 0, r);
    chk("ext_done", 8'he0, r);
    wb(0, SHIFT_ADDR, 0, r);
    chk("ext_rx", peer_tx, r);
    chk_link("ext_tx", 8'h33, peer_rx);
    wb(1, MODE_CLR_ADDR, 8'h80, r);
    wb(0, MODE_ADDR, 0, r);
    chk("clr", 8'h60, r);
    results;
  end
endmodule
`default_nettype wire
